// [hdl/bgl_gpio.sv]
// board gpio block: two eight-pin banks, board led and button, memory map decode
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// What this block does
// R1: sixteen pins in two eight-pin control registers
// R2: mode, direction, data per pin; sf bank c
// R3: data reads pin level, writes set output
// R4: all zero input; direction one output
// R5: software read-modify-writes whole word
// R6: software leaves reserved pins alone
// R7: led pin high lights led
// R8: software sets button pin as input
// R9: button pin high released, low pressed
// R10: flash 4 MB on select 0 at 0x02000000
// R11: sdram 16 MB select 1, two aliases
// R12: link and activity leds bypass gpio
// R13: reset leaves every pin a plain input
// ************************************************************
module bgl_gpio
	import bgl_pkg::*;
#(
	parameter int NPINS = BGL_PINS
) (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              nrst_i,
	// register port
	input  wire logic [7:0]        reg_addr_i,
	input  wire logic [31:0]       reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic      [31:0]       reg_rdata_o,
	// pins
	input  wire logic [NPINS-1:0]  pad_in_i,
	output logic      [NPINS-1:0]  pad_out_o,
	output logic      [NPINS-1:0]  pad_oe_n_o,
	// alternate functions
	input  wire logic [NPINS-1:0]  func_out_i,
	output logic      [NPINS-1:0]  func_in_o,
	// board indicators
	output logic                   led_power_o,
	output logic                   button_pressed_o,
	input  wire logic              link_up_i,
	input  wire logic              net_activity_i,
	output logic                   led_link_o,
	output logic                   led_activity_o,
	// memory map decode
	input  wire logic [31:0]       mem_addr_i,
	output logic                   cs_flash_o,
	output logic                   cs_sdram_o,
	output logic      [23:0]       mem_offset_o
);

	// ************************************************************
	// control state
	// ************************************************************
	logic [NPINS-1:0] func_sel;
	logic [NPINS-1:0] dir;
	logic [NPINS-1:0] spec;
	logic [NPINS-1:0] dout;
	logic [NPINS-1:0] next_func_sel;
	logic [NPINS-1:0] next_dir;
	logic [NPINS-1:0] next_spec;
	logic [NPINS-1:0] next_dout;
	logic [31:0]      next_rdata;
	logic [NPINS-1:0] gpio_out_en;
	logic [NPINS-1:0] drive_en;
	logic [NPINS-1:0] drive_lvl;
	logic [31:0]      word_a;
	logic [31:0]      word_c;

	// register writes, one bank per word
	always_comb begin
		next_func_sel = func_sel;
		next_dir      = dir;
		next_spec     = spec;
		next_dout     = dout;
		if (reg_wr_i && reg_addr_i == BGL_OFS_BANK_A) begin  // R1 R5
			next_func_sel[7:0] = reg_wdata_i[BGL_FLD_FUNC +: BGL_BANK_PINS];
			next_dir[7:0]      = reg_wdata_i[BGL_FLD_DIR  +: BGL_BANK_PINS];
			next_dout[7:0]     = reg_wdata_i[BGL_FLD_DATA +: BGL_BANK_PINS];
			next_spec[7:0]     = BGL_RST_FIELD;  // R2
		end
		if (reg_wr_i && reg_addr_i == BGL_OFS_BANK_C) begin  // R1 R5
			next_func_sel[15:8] = reg_wdata_i[BGL_FLD_FUNC +: BGL_BANK_PINS];
			next_dir[15:8]      = reg_wdata_i[BGL_FLD_DIR  +: BGL_BANK_PINS];
			next_spec[15:8]     = reg_wdata_i[BGL_FLD_SF   +: BGL_BANK_PINS];  // R2
			next_dout[15:8]     = reg_wdata_i[BGL_FLD_DATA +: BGL_BANK_PINS];  // R3
		end
	end

	// control registers, all pins inputs after reset
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			func_sel <= '0;  // R13
			dir      <= '0;  // R13
			spec     <= '0;  // R13
			dout     <= '0;
		end else begin
			func_sel <= next_func_sel;
			dir      <= next_dir;
			spec     <= next_spec;
			dout     <= next_dout;
		end
	end

	// ************************************************************
	// pin drive per pin
	// ************************************************************
	for (genvar i = 0; i < NPINS; i++) begin : g_pin
		// plain output only when mode and sf are zero and dir is one
		assign gpio_out_en[i] = !func_sel[i] && !spec[i] && dir[i];  // R4
		assign drive_en[i]    = gpio_out_en[i] || ((func_sel[i] || spec[i]) && dir[i]);
		assign drive_lvl[i]   = gpio_out_en[i] ? dout[i] : func_out_i[i];  // R3
	end

	// pad drivers registered
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pad_out_o  <= '0;
			pad_oe_n_o <= '1;
		end else begin
			pad_out_o  <= drive_lvl;
			pad_oe_n_o <= ~drive_en;  // R4
		end
	end

	// alternate functions see the pins unchanged
	assign func_in_o = pad_in_i;

	// ************************************************************
	// read back
	// ************************************************************
	assign word_a = {func_sel[7:0], dir[7:0], BGL_RST_FIELD, pad_in_i[7:0]};  // R2 R3
	assign word_c = {func_sel[15:8], dir[15:8], spec[15:8], pad_in_i[15:8]};  // R3

	// read mux, unmapped reads zero
	always_comb begin
		next_rdata = '0;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				BGL_OFS_BANK_A: next_rdata = word_a;
				BGL_OFS_BANK_C: next_rdata = word_c;
				BGL_OFS_STATUS: next_rdata = {28'h0000000, net_activity_i, link_up_i,
					button_pressed_o, led_power_o};
				default:        next_rdata = '0;
			endcase
		end
	end

	// read data one cycle later
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reg_rdata_o <= '0;
		end else begin
			reg_rdata_o <= next_rdata;
		end
	end

	// ************************************************************
	// board indicators
	// ************************************************************
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			led_power_o      <= 1'b0;
			button_pressed_o <= 1'b0;
			led_link_o       <= 1'b0;
			led_activity_o   <= 1'b0;
		end else begin
			// led lit only while a plain output drives high
			led_power_o      <= gpio_out_en[BGL_BANK_PINS+BGL_LED_BIT]
				&& dout[BGL_BANK_PINS+BGL_LED_BIT];  // R7
			// button pulls its pin low when pressed
			button_pressed_o <= !pad_in_i[BGL_BANK_PINS+BGL_BUTTON_BIT];  // R9
			// network leds follow the network hardware directly
			led_link_o       <= link_up_i;  // R12
			led_activity_o   <= net_activity_i;  // R12
		end
	end

	// ************************************************************
	// memory map decode
	// ************************************************************
	bgl_sel_t  sel;
	bgl_sel_t  next_sel;
	logic [23:0] next_offset;
	logic [31:0] flash_rel;

	assign flash_rel = mem_addr_i - BGL_FLASH_BASE;

	// select from the address, flash window then sdram aliases
	always_comb begin
		next_sel    = BGL_SEL_NONE;
		next_offset = '0;
		if (flash_rel < BGL_FLASH_SIZE) begin  // R10
			next_sel    = BGL_SEL_FLASH;
			next_offset = flash_rel[23:0];
		end else if (mem_addr_i[31:24] == BGL_SDRAM_BASE[31:24]
			|| mem_addr_i[31:24] == BGL_SDRAM_ALIAS1[31:24]
			|| mem_addr_i[31:24] == BGL_SDRAM_ALIAS2[31:24]) begin  // R11
			next_sel    = BGL_SEL_SDRAM;
			next_offset = mem_addr_i[23:0];
		end
	end

	// registered selects
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sel          <= BGL_SEL_NONE;
			mem_offset_o <= '0;
		end else begin
			sel          <= next_sel;
			mem_offset_o <= next_offset;
		end
	end

	assign cs_flash_o = (sel == BGL_SEL_FLASH);
	assign cs_sdram_o = (sel == BGL_SEL_SDRAM);

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	property p_bank_c_write;
		reg_wr_i && reg_addr_i == BGL_OFS_BANK_C
		|=> dir[15:8] == $past(reg_wdata_i[23:16]) && spec[15:8] == $past(reg_wdata_i[15:8]);
	endproperty
	a_bank_c_write: assert property (p_bank_c_write) else $error("bank c write lost");  // R1

	property p_bank_a_nosf;
		reg_rd_i && reg_addr_i == BGL_OFS_BANK_A |=> reg_rdata_o[15:8] == 8'h00;
	endproperty
	a_bank_a_nosf: assert property (p_bank_a_nosf) else $error("bank a has sf bits");  // R2

	property p_read_level;
		reg_rd_i && reg_addr_i == BGL_OFS_BANK_C |=> reg_rdata_o[7:0] == $past(pad_in_i[15:8]);
	endproperty
	a_read_level: assert property (p_read_level) else $error("read not pin level");  // R3

	property p_out_drive;
		gpio_out_en[3] |=> !pad_oe_n_o[3] && pad_out_o[3] == $past(dout[3]);
	endproperty
	a_out_drive: assert property (p_out_drive) else $error("output pin not driven");  // R4

	property p_input_float;
		!func_sel[12] && !spec[12] && !dir[12] |=> pad_oe_n_o[12];
	endproperty
	a_input_float: assert property (p_input_float) else $error("input pin driven");  // R4

	property p_led;
		gpio_out_en[14] && dout[14] |=> led_power_o;
	endproperty
	a_led: assert property (p_led) else $error("led not lit");  // R7

	property p_button;
		!pad_in_i[13] |=> button_pressed_o;
	endproperty
	a_button: assert property (p_button) else $error("button press missed");  // R9

	property p_flash;
		mem_addr_i[31:22] == 10'h008 |=> cs_flash_o && !cs_sdram_o;
	endproperty
	a_flash: assert property (p_flash) else $error("flash select wrong");  // R10

	property p_sdram;
		mem_addr_i[31:24] == 8'h08 |=> cs_sdram_o && mem_offset_o == $past(mem_addr_i[23:0]);
	endproperty
	a_sdram: assert property (p_sdram) else $error("sdram alias wrong");  // R11

	property p_link;
		link_up_i |=> led_link_o;
	endproperty
	a_link: assert property (p_link) else $error("link led wrong");  // R12

	property p_bank_a_write;
		reg_wr_i && reg_addr_i == BGL_OFS_BANK_A
		|=> func_sel[7:0] == $past(reg_wdata_i[31:24]) && dir[7:0] == $past(reg_wdata_i[23:16]);
	endproperty
	a_bank_a_write: assert property (p_bank_a_write) else $error("bank a write lost");  // R1

	property p_bank_c_data;
		reg_wr_i && reg_addr_i == BGL_OFS_BANK_C |=> dout[15:8] == $past(reg_wdata_i[7:0]);
	endproperty
	a_bank_c_data: assert property (p_bank_c_data) else $error("bank c data lost");  // R3

	property p_read_idle;
		!reg_rd_i |=> reg_rdata_o == 32'h0000_0000;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data not cleared");  // R3

	property p_alt_drive;
		(func_sel[2] || spec[2]) && dir[2]
		|=> !pad_oe_n_o[2] && pad_out_o[2] == $past(func_out_i[2]);
	endproperty
	a_alt_drive: assert property (p_alt_drive) else $error("alternate pin not driven");  // R4

	property p_led_off;
		!(gpio_out_en[14] && dout[14]) |=> !led_power_o;
	endproperty
	a_led_off: assert property (p_led_off) else $error("led lit wrongly");  // R7

	property p_released;
		pad_in_i[13] |=> !button_pressed_o;
	endproperty
	a_released: assert property (p_released) else $error("button release missed");  // R9

	property p_flash_offset;
		mem_addr_i[31:22] == 10'h008 |=> mem_offset_o == {2'b00, $past(mem_addr_i[21:0])};
	endproperty
	a_flash_offset: assert property (p_flash_offset) else $error("flash offset wrong");  // R10

	property p_sdram_base;
		mem_addr_i[31:24] == 8'h00 |=> cs_sdram_o && !cs_flash_o;
	endproperty
	a_sdram_base: assert property (p_sdram_base) else $error("sdram base wrong");  // R11

	property p_sdram_alias1;
		mem_addr_i[31:24] == 8'h04 |=> cs_sdram_o && mem_offset_o == $past(mem_addr_i[23:0]);
	endproperty
	a_sdram_alias1: assert property (p_sdram_alias1) else $error("sdram alias wrong");  // R11

	property p_unmapped;
		mem_addr_i[31:22] != 10'h008 && !(mem_addr_i[31:24] inside {8'h00, 8'h04, 8'h08})
		|=> !cs_flash_o && !cs_sdram_o;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("select outside map");  // R11

	property p_activity;
		net_activity_i |=> led_activity_o;
	endproperty
	a_activity: assert property (p_activity) else $error("activity led wrong");  // R12

	property p_link_down;
		!link_up_i |=> !led_link_o;
	endproperty
	a_link_down: assert property (p_link_down) else $error("link led stuck");  // R12

	property p_reset_input;
		$rose(nrst_i) |-> pad_oe_n_o == '1;
	endproperty
	a_reset_input: assert property (p_reset_input) else $error("pin driven after reset");  // R13

	c_led_on:   cover property (led_power_o);
	c_press:    cover property (button_pressed_o);
	c_sdram:    cover property (cs_sdram_o);
	c_rmw:      cover property (reg_rd_i ##1 reg_wr_i);

endmodule
`default_nettype wire

// [common/bgl_pkg.sv]
// constants, offsets and field layout of the board gpio block
package bgl_pkg;
	// register byte offsets
	localparam logic [7:0] BGL_OFS_BANK_A = 8'h00;
	localparam logic [7:0] BGL_OFS_BANK_C = 8'h04;
	localparam logic [7:0] BGL_OFS_STATUS = 8'h08;
	// field positions inside a bank control word
	localparam int BGL_FLD_FUNC = 24;
	localparam int BGL_FLD_DIR  = 16;
	localparam int BGL_FLD_SF   = 8;
	localparam int BGL_FLD_DATA = 0;
	// geometry
	localparam int BGL_PINS      = 16;
	localparam int BGL_BANK_PINS = 8;
	// reset value of every control field
	localparam logic [7:0] BGL_RST_FIELD = 8'h00;
	// board pins inside bank c
	localparam int BGL_LED_BIT    = 6;
	localparam int BGL_BUTTON_BIT = 5;
	// memory map
	localparam logic [31:0] BGL_FLASH_BASE  = 32'h0200_0000;
	localparam logic [31:0] BGL_FLASH_SIZE  = 32'h0040_0000;
	localparam logic [31:0] BGL_SDRAM_BASE  = 32'h0000_0000;
	localparam logic [31:0] BGL_SDRAM_ALIAS1 = 32'h0400_0000;
	localparam logic [31:0] BGL_SDRAM_ALIAS2 = 32'h0800_0000;
	localparam logic [31:0] BGL_SDRAM_SIZE  = 32'h0100_0000;
	// decode result of the memory map
	typedef enum logic [1:0] {
		BGL_SEL_NONE,
		BGL_SEL_FLASH,
		BGL_SEL_SDRAM
	} bgl_sel_t;
endpackage

// [test/bgl_board.sv]
// board side model: pin wiring, pushbutton with pull-up, outside drivers
`timescale 1ns/1ps
`default_nettype none
module bgl_board (
	// design pins
	input  wire logic [15:0] pad_out_i,
	input  wire logic [15:0] pad_oe_n_i,
	// outside world
	input  wire logic [15:0] ext_i,
	input  wire logic        press_i,
	output logic      [15:0] pad_o
);
	// driven pins show the design level, pin 13 the button, the rest the outside drivers
	always_comb begin
		pad_o = ext_i;
		pad_o[13] = ~press_i;
		for (int i = 0; i < 16; i++) begin
			if (!pad_oe_n_i[i]) pad_o[i] = pad_out_i[i];
		end
	end
endmodule
`default_nettype wire

// [test/board_gpio_led_button_map_tb.sv]
// self-checking bench for the board gpio block
`timescale 1ns/1ps
`default_nettype none
module board_gpio_led_button_map_tb;
	import bgl_pkg::*;
	logic        clk_i, nrst_i, wr_s, rd_s, rd_d, press, link, act, fsel, ssel;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, mem_addr, ctl_a, ctl_c, eoff;
	logic [15:0] pad_in, pad_out, oe_n, ext, fout, fin;
	logic        led, btn, led_l, led_a, cs_f, cs_s;
	logic [23:0] moff;
	logic [31:0] exp_q[$];
	int          fails, samples_checked, seed;
	logic [31:0] ma [8] = '{32'h0200_0000, 32'h023f_ffff, 32'h0240_0000, 32'h0000_0010,
		32'h0412_3456, 32'h08ab_cdef, 32'h0c00_0000, 32'h0100_0000};
	bgl_gpio u_bgl_gpio (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
		.pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_n_o(oe_n), .func_out_i(fout),
		.func_in_o(fin), .led_power_o(led), .button_pressed_o(btn), .link_up_i(link),
		.net_activity_i(act), .led_link_o(led_l), .led_activity_o(led_a),
		.mem_addr_i(mem_addr), .cs_flash_o(cs_f), .cs_sdram_o(cs_s), .mem_offset_o(moff));
	bgl_board u_bgl_board (.pad_out_i(pad_out), .pad_oe_n_i(oe_n), .ext_i(ext),
		.press_i(press), .pad_o(pad_in));
	// clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic complete_run();
		if (fails == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk_i);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_i);
		addr <= a;
		rd_s <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk_i);
		rd_s <= 1'b0;
	endtask
	// expected pin levels from the control words and outside drivers
	function automatic logic [15:0] lvl();
		logic [15:0] d, l;
		d = {ctl_c[23:16] & ~ctl_c[31:24] & ~ctl_c[15:8], ctl_a[23:16] & ~ctl_a[31:24]};
		l = ext;
		l[13] = ~press;
		return (d & {ctl_c[7:0], ctl_a[7:0]}) | (~d & l);
	endfunction
	function automatic logic [31:0] exp_a();
		logic [15:0] l;
		l = lvl();
		return {ctl_a[31:16], 8'h00, l[7:0]};
	endfunction
	function automatic logic [31:0] exp_c();
		logic [15:0] l;
		l = lvl();
		return {ctl_c[31:8], l[15:8]};
	endfunction
	// read data stands one cycle after the strobe
	always @(posedge clk_i) begin
		rd_d <= rd_s;
		if (rd_d) check("rdata", rdata, exp_q.pop_front());
	end
	// watchdog
	initial begin
		#100000;
		fails++;
		complete_run();
	end
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		seed = 35097;
		{nrst_i, wr_s, rd_s, press, link, act, addr, wdata, mem_addr} = '0;
		{ctl_a, ctl_c} = '0;
		ext = 16'h5a3c;
		fout = 16'h0000;
		repeat (20) @(posedge clk_i);
		nrst_i <= 1'b1;
		#1 check("oe_n", oe_n, 16'hffff);
		rd(BGL_OFS_BANK_A, exp_a());
		rd(BGL_OFS_BANK_C, exp_c());
		// led pin plain output driven high, button pin left a plain input
		ctl_c = 32'h0040_0040;
		wr(BGL_OFS_BANK_C, ctl_c);
		rd(BGL_OFS_BANK_C, exp_c());
		#1 check("led", led, 1'b1);
		check("oe14", oe_n[14], 1'b0);
		check("out14", pad_out[14], 1'b1);
		// bank a random plain pins, sf field never kept
		for (int k = 0; k < 6; k++) begin
			@(posedge clk_i);
			ext <= 16'($random(seed));
			fout <= 16'($random(seed));
			ctl_a = $random(seed);
			wr(BGL_OFS_BANK_A, ctl_a & 32'h00ff_ffff);
			ctl_a = ctl_a & 32'h00ff_00ff;
			rd(BGL_OFS_BANK_A, exp_a());
			#1 check("oe_a", oe_n[7:0], 8'(~ctl_a[23:16]));
			check("out_a", pad_out[7:0] & ctl_a[23:16], ctl_a[7:0] & ctl_a[23:16]);
			check("fin", fin, lvl());
		end
		// read-modify-write back to back, only the led data bit changes
		@(posedge clk_i);
		addr <= BGL_OFS_BANK_C;
		rd_s <= 1'b1;
		exp_q.push_back(exp_c());
		@(posedge clk_i);
		rd_s <= 1'b0;
		ctl_c = ctl_c & ~32'h0000_0040;
		wdata <= ctl_c;
		wr_s <= 1'b1;
		@(posedge clk_i);
		wr_s <= 1'b0;
		rd(BGL_OFS_BANK_C, exp_c());
		#1 check("led_off", led, 1'b0);
		check("out14_off", pad_out[14], 1'b0);
		// button press and network leds
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_i);
			{press, link, act} <= 3'($random(seed));
			repeat (2) @(posedge clk_i);
			#1 check("btn", btn, press);
			check("lnk", led_l, link);
			check("act", led_a, act);
			rd(BGL_OFS_STATUS, {28'h0, act, link, press, ctl_c[22] & ctl_c[6]});
			rd(BGL_OFS_BANK_C, exp_c());
		end
		// unmapped place is ignored and reads zero
		wr(8'h0c, 32'hffff_ffff);
		rd(8'h0c, 32'h0);
		rd(BGL_OFS_BANK_A, exp_a());
		// mode set hands the pins to the alternate function
		wr(BGL_OFS_BANK_A, 32'hffff_0000);
		repeat (2) @(posedge clk_i);
		#1 check("oe_f", oe_n[7:0], 8'h00);
		check("out_f", pad_out[7:0], fout[7:0]);
		// reset in mid-run returns every pin to a plain input
		@(posedge clk_i);
		nrst_i <= 1'b0;
		#1 check("oe_rst", oe_n, 16'hffff);
		check("led_rst", led, 1'b0);
		{ctl_a, ctl_c} = '0;
		@(posedge clk_i);
		nrst_i <= 1'b1;
		rd(BGL_OFS_BANK_C, exp_c());
		// memory map
		for (int k = 0; k < 8; k++) begin
			@(posedge clk_i);
			mem_addr <= ma[k];
			fsel = (ma[k] - BGL_FLASH_BASE) < BGL_FLASH_SIZE;
			ssel = ma[k][31:24] inside {8'h00, 8'h04, 8'h08};
			eoff = fsel ? ma[k] - BGL_FLASH_BASE : (ssel ? ma[k] & 32'h00ff_ffff : 32'h0);
			@(posedge clk_i);
			#1 check("csf", cs_f, fsel);
			check("css", cs_s, ssel);
			check("off", moff, eoff);
		end
		repeat (3) @(posedge clk_i);
		complete_run();
	end
endmodule
`default_nettype wire
